// ---- verif/fabric_enable_model.sv ----
// Fabric user logic model that makes every gate enable of the network.
// Assumes a free-running mclk; all enables start low.
`timescale 1ns/100ps
`default_nettype none

module fabric_enable_model
(
  input  wire logic       mclk,
  output var  logic [8:0] en
);
  initial en = 9'h000;

  // Moves 6 ns after the chosen edge, clear of the rising edge window
  task automatic drive(input logic [8:0] v, input logic hi);
    if (hi) @(posedge mclk);
    else @(negedge mclk);
    #6 en = v;
  endtask : drive
endmodule : fabric_enable_model

`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the global clock network.
// Assumes the fabric model drives enables as {row, chip, conditioner}.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic         mclk            = 1'b0;
  logic         reset_n         = 1'b0;
  logic [3:0]   chip_used       = 4'hb;
  logic [3:0]   chip_gate_on    = 4'h1;
  logic [7:0]   chip_src        = 8'h00;
  logic [3:0]   row_from_fabric = 4'h2;
  logic [3:0]   row_gate_on     = 4'h0;
  logic [7:0]   row_chip_sel    = 8'h70;
  wire  logic [8:0] en;
  logic [3:0]   chip_clk_out;
  logic [7:0]   line_l;
  logic [7:0]   line_r;
  logic [191:0] module_clk;
  logic         cond_out;
  int           n_fail          = 0;
  int           comparisons     = 0;

  always #12.5 mclk = ~mclk;

  fabric_enable_model i_fab (.mclk(mclk), .en(en));

  gated_global_clock_buffer i_dut (
    .mclk(mclk), .reset_n(reset_n), .cond_used(1'b1), .cond_gate_on(1'b1),
    .cond_en(en[0]), .conditioner_global_output(cond_out),
    .chip_used(chip_used), .chip_gate_on(chip_gate_on), .chip_en(en[4:1]),
    .chip_src(chip_src), .chip_fabric_src(4'h8), .chip_clk_out(chip_clk_out),
    .row_used(4'h7), .row_gate_on(row_gate_on), .row_en(en[8:5]),
    .row_from_fabric(row_from_fabric), .row_chip_sel(row_chip_sel),
    .row_fabric_src(4'h2), .row_clock_line_left(line_l),
    .row_clock_line_right(line_r), .module_clk(module_clk));

  task automatic chk(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  // Chip 0 gated, seen directly and through row 0
  task automatic t_gate();
    i_fab.drive(9'h000, 1'b0);
    @(posedge mclk) #8 chk(chip_clk_out[0], 1'b0, "gated off");
    i_fab.drive(9'h002, 1'b0);
    @(posedge mclk) #8 chk(chip_clk_out[0], 1'b1, "low phase enable");
    chk(module_clk[24], 1'b1, "right cluster clock");
    chk(line_l[0], 1'b1, "row line from chip");
    @(negedge mclk) #4 chk(chip_clk_out[0], 1'b0, "low phase output");
    i_fab.drive(9'h000, 1'b1);
    #4 chk(chip_clk_out[0], 1'b1, "held in high phase");
    @(posedge mclk) #8 chk(chip_clk_out[0], 1'b0, "after falling edge");
    $display("t_gate done");
  endtask : t_gate

  // Chip 1 ungated with enable low, chip 2 and row 3 unused
  task automatic t_pass();
    @(posedge mclk) #8 chk(chip_clk_out[1], 1'b1, "plain high");
    chk(chip_clk_out[2], 1'b0, "unused chip");
    chk(line_l[6], 1'b0, "unused row");
    @(negedge mclk) #4 chk(chip_clk_out[1], 1'b0, "plain low");
    $display("t_pass done");
  endtask : t_pass

  // Chip 3 walks all sources; fabric source is held high to tell them apart
  task automatic t_src();
    i_fab.drive(9'h001, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge mclk) chip_src <= 8'(k) << 6;
      @(posedge mclk) #8 chk(chip_clk_out[3], 1'b1, "source high");
      chk(line_l[4], 1'b1, "row follows chip 3");
      @(negedge mclk) #4 chk(chip_clk_out[3], k == 2, "source low");
      chk(line_r[2], 1'b1, "fabric row source");
    end
    i_fab.drive(9'h000, 1'b0);
    @(posedge mclk) #8 chk(cond_out, 1'b0, "conditioner gated");
    chk(chip_clk_out[3], 1'b0, "conditioner source off");
    $display("t_src done");
  endtask : t_src

  // Row 0 gated behind an ungated chip 0; row enable is en[5]
  task automatic t_row();
    @(posedge mclk);
    chip_gate_on <= 4'h0;
    row_gate_on  <= 4'h1;
    @(posedge mclk) #8 chk(line_l[0], 1'b0, "row gated off");
    chk(chip_clk_out[0], 1'b1, "chip 0 now plain");
    i_fab.drive(9'h020, 1'b0);
    @(posedge mclk) #8 chk(line_l[0], 1'b1, "row gate enabled");
    chk(module_clk[0], 1'b1, "left cluster clock");
    @(negedge mclk) #4 chk(line_r[0], 1'b0, "row low phase");
    $display("t_row done");
  endtask : t_row

  initial
  begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    t_gate();
    t_pass();
    t_src();
    t_row();
    summarize();
  end
endmodule : tb_top

`default_nettype wire

// ---- verilog/clk_net_pkg.sv ----
// Constants and types shared by the global clock distribution model.
// Assumes nothing of its surroundings; holds definitions only.
package clk_net_pkg;

  // Logic modules fed by one cluster clock
  localparam int CLUSTER_MODULES = 12;

  // Plain default network size
  localparam int DEF_CHIP_BUFS   = 4;
  localparam int DEF_ROW_BUFS    = 4;
  localparam int DEF_CLUSTERS    = 2;

  // Width of one chip buffer source select field
  localparam int SRC_SEL_W       = 2;

  // Value the enable latch holds while reset is asserted
  localparam logic LATCH_RESET   = 1'b0;

  // Where a chip-level buffer takes its clock from
  typedef enum logic [1:0] {
    src_pad,
    src_bidir_pad,
    src_fabric,
    src_conditioner
  } chip_src_t;

endpackage : clk_net_pkg

// ---- verilog/gated_global_clock_buffer.sv ----
// Global clock network: chip-level buffers, row buffers, row clock lines
// and cluster clocks, each buffer optionally gated by a fabric enable.
// Assumes the fabric enables and configuration levels are made by logic on
// mclk and change only away from the rising edge of the clock they gate.
`timescale 1ns/100ps
`default_nettype none

module clock_gate_cell
(
  input  wire logic clk_in,
  input  wire logic reset_n,
  input  wire logic en,
  input  wire logic gate_on,
  input  wire logic used,
  output logic      clk_out
);

  logic en_lat;
  logic cap_r;

  // Reset closes every gate so no gated buffer toggles before fabric logic is ready
  // Level sensitive hold; a flop here would add a cycle of enable latency
  always_latch
  begin
    if (!reset_n)
      en_lat <= clk_net_pkg::LATCH_RESET;
    else if (!clk_in)
      en_lat <= en;
  end

  // Unused buffers are tied low; ungated ones skip the latch entirely
  assign clk_out = used & (gate_on ? (clk_in & en_lat) : clk_in);

  // Helper: enable value taken at the rising edge, for the hold check
  always_ff @(posedge clk_in or negedge reset_n)
  begin
    if (!reset_n)
      cap_r <= clk_net_pkg::LATCH_RESET;
    else
      cap_r <= en;
  end

  latch_open_a: assert property (@(posedge clk_in) disable iff (!reset_n)
    en_lat == en) else $error("latch not transparent in low phase");

  latch_hold_a: assert property (@(negedge clk_in) disable iff (!reset_n)
    en_lat == cap_r) else $error("latch changed during high phase");

  and_low_a: assert property (@(posedge clk_in) disable iff (!reset_n)
    used && gate_on |-> !clk_out) else $error("gated output high in low phase");

  pass_high_a: assert property (@(negedge clk_in) disable iff (!reset_n)
    used && gate_on && en_lat |-> clk_out) else $error("enabled clock missing");

  stop_low_a: assert property (@(negedge clk_in) disable iff (!reset_n)
    used && gate_on && !en_lat |-> !clk_out) else $error("disabled clock not low");

  late_change_a: assert property (@(negedge clk_in) disable iff (!reset_n)
    used && gate_on && $changed(cap_r) |-> clk_out == cap_r)
    else $error("high phase enable change acted early");

  tie_off_a: assert property (@(negedge clk_in) disable iff (!reset_n)
    !used |-> !clk_out) else $error("unused buffer toggles");

  bypass_a: assert property (@(negedge clk_in) disable iff (!reset_n)
    used && !gate_on |-> clk_out) else $error("ungated buffer lost clock");

  // Reset parks a gated buffer low even while its incoming clock keeps running
  reset_park_a: assert property (@(negedge clk_in)
    !reset_n && used && gate_on
    |-> !clk_out)
    else $error("gated output ran during reset");

  reset_latch_a: assert property (@(posedge clk_in)
    !reset_n
    |-> en_lat == clk_net_pkg::LATCH_RESET)
    else $error("latch left its reset value");

  // A low phase enable must be in the latch before the edge that it gates
  early_change_a: assert property (@(posedge clk_in) disable iff (!reset_n)
    used && gate_on && en
    |-> en_lat)
    else $error("low phase enable missed the latch");

endmodule : clock_gate_cell

module gated_global_clock_buffer
#(
  parameter int N_CHIP     = clk_net_pkg::DEF_CHIP_BUFS,
  parameter int N_ROW      = clk_net_pkg::DEF_ROW_BUFS,
  parameter int N_CLUSTER  = clk_net_pkg::DEF_CLUSTERS,
  parameter int MODULES    = clk_net_pkg::CLUSTER_MODULES,
  parameter int SEL_W      = (N_CHIP > 1) ? $clog2(N_CHIP) : 1
)
(
  input  wire logic                              mclk,
  input  wire logic                              reset_n,
  input  wire logic                              cond_used,
  input  wire logic                              cond_gate_on,
  input  wire logic                              cond_en,
  output logic                                   conditioner_global_output,
  input  wire logic [N_CHIP-1:0]                 chip_used,
  input  wire logic [N_CHIP-1:0]                 chip_gate_on,
  input  wire logic [N_CHIP-1:0]                 chip_en,
  input  wire logic [N_CHIP*clk_net_pkg::SRC_SEL_W-1:0] chip_src,
  input  wire logic [N_CHIP-1:0]                 chip_fabric_src,
  output logic      [N_CHIP-1:0]                 chip_clk_out,
  input  wire logic [N_ROW-1:0]                  row_used,
  input  wire logic [N_ROW-1:0]                  row_gate_on,
  input  wire logic [N_ROW-1:0]                  row_en,
  input  wire logic [N_ROW-1:0]                  row_from_fabric,
  input  wire logic [N_ROW*SEL_W-1:0]            row_chip_sel,
  input  wire logic [N_ROW-1:0]                  row_fabric_src,
  output logic      [N_ROW*N_CLUSTER-1:0]        row_clock_line_left,
  output logic      [N_ROW*N_CLUSTER-1:0]        row_clock_line_right,
  output logic      [N_ROW*2*N_CLUSTER*MODULES-1:0] module_clk
);

  logic [N_CHIP-1:0] chip_in;
  logic [N_ROW-1:0]  row_in;
  logic [N_ROW-1:0]  row_clk;

  // Conditioner output is itself a gated clock that may feed chip buffers
  clock_gate_cell u_cond_gate
  (
    .clk_in  (mclk),
    .reset_n (reset_n),
    .en      (cond_en),
    .gate_on (cond_gate_on),
    .used    (cond_used),
    .clk_out (conditioner_global_output)
  );

  for (genvar i = 0; i < N_CHIP; i++)
  begin : g_chip
    clk_net_pkg::chip_src_t src;

    assign src = clk_net_pkg::chip_src_t'(chip_src[i*clk_net_pkg::SRC_SEL_W +:
                                                    clk_net_pkg::SRC_SEL_W]);

    // Both pad kinds deliver the same incoming clock
    always_comb
    begin
      case (src)
        clk_net_pkg::src_pad:         chip_in[i] = mclk;
        clk_net_pkg::src_bidir_pad:   chip_in[i] = mclk;
        clk_net_pkg::src_fabric:      chip_in[i] = chip_fabric_src[i];
        clk_net_pkg::src_conditioner: chip_in[i] = conditioner_global_output;
        default:                      chip_in[i] = 1'b0;
      endcase
    end

    clock_gate_cell u_chip_gate
    (
      .clk_in  (chip_in[i]),
      .reset_n (reset_n),
      .en      (chip_en[i]),
      .gate_on (chip_gate_on[i]),
      .used    (chip_used[i]),
      .clk_out (chip_clk_out[i])
    );

    // Ungated chip buffers must show their chosen source without delay or gating
    chip_pad_a: assert property (@(negedge mclk) disable iff (!reset_n)
      chip_used[i] && !chip_gate_on[i]
      && (src == clk_net_pkg::src_pad || src == clk_net_pkg::src_bidir_pad)
      |-> chip_clk_out[i])
      else $error("pad clock did not reach chip buffer");

    chip_fabric_a: assert property (@(negedge mclk) disable iff (!reset_n)
      chip_used[i] && !chip_gate_on[i] && src == clk_net_pkg::src_fabric
      |-> chip_clk_out[i] == chip_fabric_src[i])
      else $error("fabric clock did not reach chip buffer");

    chip_cond_a: assert property (@(negedge mclk) disable iff (!reset_n)
      chip_used[i] && !chip_gate_on[i] && src == clk_net_pkg::src_conditioner
      |-> chip_clk_out[i] == conditioner_global_output)
      else $error("conditioner clock did not reach chip buffer");

    chip_unused_a: assert property (@(negedge mclk) disable iff (!reset_n)
      !chip_used[i]
      |-> !chip_clk_out[i])
      else $error("unused chip buffer toggles");

    // Low phase is low on every pad-fed buffer, gated or not
    chip_low_a: assert property (@(posedge mclk) disable iff (!reset_n)
      chip_used[i]
      && (src == clk_net_pkg::src_pad || src == clk_net_pkg::src_bidir_pad)
      |-> !chip_clk_out[i])
      else $error("pad-fed chip buffer high in low phase");

    // Checked without a disable so that reset itself is covered
    chip_reset_a: assert property (@(negedge mclk)
      !reset_n && chip_used[i] && chip_gate_on[i]
      |-> !chip_clk_out[i])
      else $error("gated chip buffer ran during reset");
  end

  for (genvar j = 0; j < N_ROW; j++)
  begin : g_row
    logic [SEL_W-1:0] sel;

    assign sel = row_chip_sel[j*SEL_W +: SEL_W];

    // Any chip buffer reaches any row; an out-of-range pick gives no clock
    always_comb
    begin
      if (row_from_fabric[j])
        row_in[j] = row_fabric_src[j];
      else if (int'(sel) < N_CHIP)
        row_in[j] = chip_clk_out[sel];
      else
        row_in[j] = 1'b0;
    end

    clock_gate_cell u_row_gate
    (
      .clk_in  (row_in[j]),
      .reset_n (reset_n),
      .en      (row_en[j]),
      .gate_on (row_gate_on[j]),
      .used    (row_used[j]),
      .clk_out (row_clk[j])
    );

    for (genvar c = 0; c < N_CLUSTER; c++)
    begin : g_cluster
      assign row_clock_line_left[j*N_CLUSTER+c]  = row_clk[j];
      assign row_clock_line_right[j*N_CLUSTER+c] = row_clk[j];
      assign module_clk[((j*2)*N_CLUSTER+c)*MODULES +: MODULES] =
        {MODULES{row_clock_line_left[j*N_CLUSTER+c]}};
      assign module_clk[((j*2+1)*N_CLUSTER+c)*MODULES +: MODULES] =
        {MODULES{row_clock_line_right[j*N_CLUSTER+c]}};

      cluster_clk_a: assert property (@(negedge mclk) disable iff (!reset_n)
        module_clk[((j*2)*N_CLUSTER+c)*MODULES +: MODULES] == {MODULES{row_clk[j]}}
        && module_clk[((j*2+1)*N_CLUSTER+c)*MODULES +: MODULES] == {MODULES{row_clk[j]}})
        else $error("cluster modules disagree with row buffer");
    end

    row_fabric_a: assert property (@(negedge mclk) disable iff (!reset_n)
      row_used[j] && !row_gate_on[j] && row_from_fabric[j]
      |-> row_clk[j] == row_fabric_src[j])
      else $error("row buffer ignored fabric source");

    row_chip_a: assert property (@(negedge mclk) disable iff (!reset_n)
      row_used[j] && !row_gate_on[j] && !row_from_fabric[j] && int'(sel) < N_CHIP
      |-> row_clk[j] == chip_clk_out[sel])
      else $error("row buffer ignored chip buffer");

    row_fanout_a: assert property (@(negedge mclk) disable iff (!reset_n)
      module_clk[(j*2+1)*N_CLUSTER*MODULES] == row_clk[j]
      && module_clk[j*2*N_CLUSTER*MODULES] == row_clk[j])
      else $error("cluster clock differs from row buffer");

    // Tie-offs are checked per row so a wrong index shows where it lies
    row_unused_a: assert property (@(negedge mclk) disable iff (!reset_n)
      !row_used[j]
      |-> !row_clk[j])
      else $error("unused row buffer toggles");

    row_sides_a: assert property (@(negedge mclk) disable iff (!reset_n)
      row_clock_line_left[j*N_CLUSTER] == row_clock_line_right[j*N_CLUSTER])
      else $error("left and right row lines differ");

    // A stopped chip buffer can never be revived by a row buffer below it
    row_low_a: assert property (@(negedge mclk) disable iff (!reset_n)
      row_used[j] && !row_from_fabric[j] && int'(sel) < N_CHIP && !chip_clk_out[sel]
      |-> !row_clk[j])
      else $error("row buffer high under a stopped chip buffer");
  end

  // Conditioner output is sampled against mclk directly, where its latch lives
  cond_low_a: assert property (@(posedge mclk) disable iff (!reset_n)
    cond_used
    |-> !conditioner_global_output)
    else $error("conditioner output high in low phase");

  cond_reset_a: assert property (@(negedge mclk)
    !reset_n && cond_used && cond_gate_on
    |-> !conditioner_global_output)
    else $error("conditioner ran during reset");

endmodule : gated_global_clock_buffer

`default_nettype wire
